// ---- src/vit_pkg.sv ----
// shared constants and carrier types for the vectored interrupt and trap block
package vit_pkg;

    // trap csr addresses
    localparam logic [11:0] CSR_STATUS_ADDR  = 12'h300;
    localparam logic [11:0] CSR_TVEC_ADDR    = 12'h305;
    localparam logic [11:0] CSR_SCRATCH_ADDR = 12'h340;
    localparam logic [11:0] CSR_EPC_ADDR     = 12'h341;
    localparam logic [11:0] CSR_CAUSE_ADDR   = 12'h342;
    localparam logic [11:0] CSR_TVAL_ADDR    = 12'h343;

    // interrupt controller register byte offsets
    localparam logic [11:0] INT_ENABLE_OFS = 12'h104;
    localparam logic [11:0] INT_TYPE_OFS   = 12'h108;
    localparam logic [11:0] INT_CLEAR_OFS  = 12'h10C;
    localparam logic [11:0] INT_PEND_OFS   = 12'h110;
    localparam logic [11:0] INT_PRIO_OFS   = 12'h118;
    localparam logic [11:0] INT_THRESH_OFS = 12'h194;

    // field positions and fixed values
    localparam int          STATUS_MIE_BIT  = 3;
    localparam int          STATUS_PREV_GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int          CAUSE_IRQ_BIT   = 31;
    localparam int          TVEC_BASE_LSB   = 8;
    localparam logic [7:0]  TVEC_LOW_BITS   = 8'h01;
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
    localparam logic [3:0]  PRIO_RESET      = 4'h0;

    // exception codes
    localparam logic [4:0] EXC_INSN_FAULT  = 5'h01;
    localparam logic [4:0] EXC_ILLEGAL     = 5'h02;
    localparam logic [4:0] EXC_BREAK       = 5'h03;
    localparam logic [4:0] EXC_LOAD_FAULT  = 5'h05;
    localparam logic [4:0] EXC_STORE_FAULT = 5'h07;
    localparam logic [4:0] EXC_ECALL_U     = 5'h08;
    localparam logic [4:0] EXC_ECALL_M     = 5'h0B;

    // cycles from source assertion to trap entry
    localparam int IRQ_LATENCY = 4;

    typedef struct packed {
        logic        valid;
        logic [4:0]  code;
        logic [31:0] pc;
        logic [31:0] opcode;
        logic [31:0] daddr;
    } vit_exc_t;

    typedef struct packed {
        logic        taken;
        logic        is_irq;
        logic [4:0]  code;
        logic [31:0] target;
    } vit_trap_t;

endpackage

// ---- src/vit_irq_cell.sv ----
// one interrupt source: capture, masking and clear handling
`timescale 1ns/100ps
module vit_irq_cell
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       src,
    input  wire logic       enable,
    input  wire logic       edge_type,
    input  wire logic [3:0] prio,
    input  wire logic [3:0] thresh,
    input  wire logic       clr_bit,
    input  wire logic       claim,
    output logic            pend_r
);
    import vit_pkg::*;

    logic src_d_r;
    logic clr_d_r;
    logic latch_r;
    logic claimed_r;
    logic latch_nxt;
    logic claimed_nxt;
    logic pend_nxt;

    wire rise     = src & ~src_d_r;
    wire clr_fall = clr_d_r & ~clr_bit;                           // RULE15
    wire unmasked = (prio != PRIO_RESET) && (prio >= thresh);     // RULE11
    // only claimed edges, or unclaimed ones already disabled, may be flushed
    wire flush    = clr_fall & edge_type & (claimed_r | ~enable); // RULE15 RULE16
    // a new edge in the clearing cycle wins over the clear
    assign latch_nxt   = (enable & edge_type & rise) ? 1'b1 : (flush ? 1'b0 : latch_r); // RULE10
    assign claimed_nxt = claim ? 1'b1 : (flush ? 1'b0 : claimed_r);
    // level sources pass the live input, edge sources the latch
    assign pend_nxt    = enable & unmasked & (edge_type ? latch_nxt : src); // RULE9 RULE10

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            src_d_r   <= 1'b0;
            clr_d_r   <= 1'b0;
            latch_r   <= 1'b0;
            claimed_r <= 1'b0;
            pend_r    <= 1'b0;
        end
        else
        begin
            src_d_r   <= src;
            clr_d_r   <= clr_bit;
            latch_r   <= latch_nxt;
            claimed_r <= claimed_nxt;
            pend_r    <= pend_nxt;
        end
    end

    AST_PEND_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
        pend_r |-> $past(enable) && ($past(prio) >= $past(thresh)) && ($past(prio) != 4'h0))
        else $error("pending set for a disabled or masked source");

    AST_LEVEL_NOT_CLEARED: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
        (!edge_type && enable && unmasked && src && clr_fall) |=> pend_r)
        else $error("clear toggle dropped a level source");

endmodule // vit_irq_cell

// ---- src/vit_trap_ctrl.sv ----
// prioritising interrupt controller with trap entry csrs
`timescale 1ns/100ps
// Function
// RULE1 - vector mode hard-wired to vectored, 0x1
// RULE2 - vector base holds upper 24 address bits
// RULE3 - return pc gets instruction about to execute
// RULE4 - cause code reports listed exception numbers
// RULE5 - fetch address lsb forced, code zero never
// RULE6 - cause interrupt flag set only for interrupts
// RULE7 - trap value chosen by exception code
// RULE8 - up to 31 sources numbered 1-31
// RULE9 - only enabled sources captured and serviced
// RULE10 - type bit: 0 level, 1 rising edge
// RULE11 - priority 1-15; zero or below threshold masked
// RULE12 - equal priority: lowest number wins
// RULE13 - read-only pending register per source
// RULE14 - highest priority pending traps, then claimed
// RULE15 - clear pulse drops claimed edge pending only
// RULE16 - disable then clear pulse flushes unclaimed edge
// RULE17 - interrupt entry saves pc, cause, enable bits
// RULE18 - jump to base plus four times number
// RULE19 - source number zero never captures
// RULE20 - cause bit 31 interrupt flag, low five code
// RULE21 - exactly four cycles input to trap entry
// RULE22 - no interrupt trap while global enable clear
module vit_trap_ctrl #(
    parameter int NUM_IRQ = 31
)
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [NUM_IRQ:1]  irq_src,
    input  wire logic [11:0]       csr_addr,
    input  wire logic              csr_we,
    input  wire logic [31:0]       csr_wdata,
    output logic [31:0]            csr_rdata_r,
    input  wire logic [11:0]       reg_addr,
    input  wire logic              reg_we,
    input  wire logic [31:0]       reg_wdata,
    output logic [31:0]            reg_rdata_r,
    input  wire logic [31:0]       core_next_pc,
    input  wire logic              core_mret,
    input  wire vit_pkg::vit_exc_t exc_in,
    input  wire logic [31:0]       fetch_addr,
    output logic [31:0]            fetch_addr_aligned,
    output vit_pkg::vit_trap_t     trap_r
);
    import vit_pkg::*;

    logic [31:0]        enable_r;
    logic [31:0]        type_r;
    logic [31:0]        clear_r;
    logic [3:0]         prio_r [1:NUM_IRQ];
    logic [3:0]         thresh_r;
    logic [NUM_IRQ:1]   pend;
    logic [NUM_IRQ:1]   claim_vec;
    logic [4:0]         best_id_r;
    logic               best_valid_r;
    logic [4:0]         req_id_r;
    logic               req_r;
    logic [23:0]        tvec_base_r;
    logic [31:0]        scratch_r;
    logic [31:0]        epc_r;
    logic [31:0]        cause_r;
    logic [31:0]        tval_r;
    logic               global_irq_enable_r;
    logic               prev_global_irq_enable_r;
    logic [4:0]         best_id_nxt;
    logic               best_valid_nxt;
    logic [31:0]        tval_nxt;
    logic [31:0]        prio_rd;

    function automatic logic [11:0] prio_ofs(input int idx);
        prio_ofs = INT_PRIO_OFS + 12'((idx - 1) * 4);
    endfunction

    // lsb dropped so a misaligned fetch fault cannot arise
    assign fetch_addr_aligned = {fetch_addr[31:1], 1'b0}; // RULE5

    genvar g;
    generate
        for (g = 1; g <= NUM_IRQ; g = g + 1)
        begin : gen_cell
            vit_irq_cell u_cell (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .src       (irq_src[g]),
                .enable    (enable_r[g]),
                .edge_type (type_r[g]),
                .prio      (prio_r[g]),
                .thresh    (thresh_r),
                .clr_bit   (clear_r[g]),
                .claim     (claim_vec[g]),
                .pend_r    (pend[g])
            ); // RULE8
        end
    endgenerate

    // arbitration: highest priority, lowest number on a tie
    always_comb
    begin
        logic [3:0] best_pri;
        best_pri       = 4'h0;
        best_id_nxt    = 5'h00;
        best_valid_nxt = 1'b0;
        for (int i = NUM_IRQ; i >= 1; i--)
        begin
            if (pend[i] && (prio_r[i] >= best_pri)) // RULE12
            begin
                best_pri       = prio_r[i];
                best_id_nxt    = 5'(i);
                best_valid_nxt = 1'b1;
            end
        end
    end

    // pipeline: pend (1), select (2), request (3), trap entry (4)
    wire irq_go  = req_r && pend[req_id_r] && global_irq_enable_r && !exc_in.valid; // RULE14 RULE22
    wire take    = exc_in.valid || irq_go;
    wire [4:0] take_code = exc_in.valid ? exc_in.code : req_id_r;

    assign claim_vec = irq_go ? (NUM_IRQ'(1) << (req_id_r - 5'h01)) : '0; // RULE14

    always_comb
    begin
        unique case (exc_in.code) // RULE7
            EXC_INSN_FAULT:  tval_nxt = exc_in.pc;
            EXC_ILLEGAL:     tval_nxt = exc_in.opcode;
            EXC_LOAD_FAULT:  tval_nxt = exc_in.daddr;
            EXC_STORE_FAULT: tval_nxt = exc_in.daddr;
            default:         tval_nxt = RESET_WORD;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            best_id_r    <= 5'h00;
            best_valid_r <= 1'b0;
            req_id_r     <= 5'h00;
            req_r        <= 1'b0;
        end
        else
        begin
            best_id_r    <= best_id_nxt;
            best_valid_r <= best_valid_nxt;
            req_id_r     <= best_id_r;
            req_r        <= best_valid_r; // RULE21
        end
    end

    // interrupt controller register writes
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            enable_r <= RESET_WORD;
            type_r   <= RESET_WORD;
            clear_r  <= RESET_WORD;
            thresh_r <= PRIO_RESET;
            for (int i = 1; i <= NUM_IRQ; i++)
                prio_r[i] <= PRIO_RESET;
        end
        else if (reg_we)
        begin
            if (reg_addr == INT_ENABLE_OFS)
                enable_r <= {reg_wdata[31:1], 1'b0}; // RULE19
            if (reg_addr == INT_TYPE_OFS)
                type_r <= {reg_wdata[31:1], 1'b0};
            if (reg_addr == INT_CLEAR_OFS)
                clear_r <= {reg_wdata[31:1], 1'b0};
            if (reg_addr == INT_THRESH_OFS)
                thresh_r <= reg_wdata[3:0];
            for (int i = 1; i <= NUM_IRQ; i++)
                if (reg_addr == prio_ofs(i))
                    prio_r[i] <= reg_wdata[3:0]; // RULE11
        end
    end

    always_comb
    begin
        prio_rd = RESET_WORD;
        for (int i = 1; i <= NUM_IRQ; i++)
            if (reg_addr == prio_ofs(i))
                prio_rd = {28'h0, prio_r[i]};
    end

    wire [31:0] pend_word = 32'({pend, 1'b0});
    wire [31:0] reg_rd_mux =
        (reg_addr == INT_ENABLE_OFS) ? enable_r :
        (reg_addr == INT_TYPE_OFS)   ? type_r :
        (reg_addr == INT_CLEAR_OFS)  ? clear_r :
        (reg_addr == INT_PEND_OFS)   ? pend_word : // RULE13
        (reg_addr == INT_THRESH_OFS) ? {28'h0, thresh_r} : prio_rd;

    wire [31:0] tvec_word   = {tvec_base_r, TVEC_LOW_BITS}; // RULE1 RULE2
    wire [31:0] status_word = 32'({prev_global_irq_enable_r, 3'b000,
                                   global_irq_enable_r, 3'b000});
    wire [31:0] csr_rd_mux =
        (csr_addr == CSR_STATUS_ADDR)  ? status_word :
        (csr_addr == CSR_TVEC_ADDR)    ? tvec_word :
        (csr_addr == CSR_SCRATCH_ADDR) ? scratch_r :
        (csr_addr == CSR_EPC_ADDR)     ? epc_r :
        (csr_addr == CSR_CAUSE_ADDR)   ? cause_r :
        (csr_addr == CSR_TVAL_ADDR)    ? tval_r : RESET_WORD;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata_r <= RESET_WORD;
            csr_rdata_r <= RESET_WORD;
        end
        else
        begin
            reg_rdata_r <= reg_rd_mux;
            csr_rdata_r <= csr_rd_mux;
        end
    end

    // trap csrs; trap entry outranks a software write in the same cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tvec_base_r              <= 24'h00_0000;
            scratch_r                <= RESET_WORD;
            epc_r                    <= RESET_WORD;
            cause_r                  <= RESET_WORD;
            tval_r                   <= RESET_WORD;
            global_irq_enable_r      <= 1'b0;
            prev_global_irq_enable_r <= 1'b0;
        end
        else if (take)
        begin
            epc_r   <= exc_in.valid ? exc_in.pc : core_next_pc; // RULE3 RULE17
            cause_r <= {!exc_in.valid, 26'h0, take_code}; // RULE4 RULE6 RULE20
            if (exc_in.valid)
                tval_r <= tval_nxt; // RULE7
            prev_global_irq_enable_r <= global_irq_enable_r; // RULE17
            global_irq_enable_r      <= 1'b0;
        end
        else if (core_mret)
        begin
            global_irq_enable_r      <= prev_global_irq_enable_r;
            prev_global_irq_enable_r <= 1'b0;
        end
        else if (csr_we)
        begin
            unique case (csr_addr)
                CSR_STATUS_ADDR:
                begin
                    global_irq_enable_r      <= csr_wdata[STATUS_MIE_BIT];
                    prev_global_irq_enable_r <= csr_wdata[STATUS_PREV_GLOBAL_IRQ_ENABLE_BIT];
                end
                CSR_TVEC_ADDR:    tvec_base_r <= csr_wdata[31:TVEC_BASE_LSB]; // RULE2
                CSR_SCRATCH_ADDR: scratch_r <= csr_wdata;
                CSR_EPC_ADDR:     epc_r <= csr_wdata;
                CSR_CAUSE_ADDR:   cause_r <= {csr_wdata[CAUSE_IRQ_BIT], 26'h0, csr_wdata[4:0]};
                CSR_TVAL_ADDR:    tval_r <= csr_wdata;
                default:          scratch_r <= scratch_r;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            trap_r <= '0;
        else
        begin
            trap_r.taken  <= take;
            trap_r.is_irq <= !exc_in.valid;
            trap_r.code   <= take_code;
            // exceptions use entry 0, interrupt i uses entry 4i
            trap_r.target <= {tvec_base_r, 8'h00}
                             + (exc_in.valid ? 32'h0 : {25'h0, req_id_r, 2'b00}); // RULE18
        end
    end

    AST_TVEC_MODE_FIXED: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        (csr_we && csr_addr == CSR_TVEC_ADDR && !take && !core_mret)
        |=> tvec_word[7:0] == 8'h01 && tvec_word[31:8] == $past(csr_wdata[31:8]))
        else $error("vector register low byte not vectored mode");

    AST_EPC_EXC: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
        exc_in.valid |=> epc_r == $past(exc_in.pc))
        else $error("return pc not the faulting instruction");

    AST_EPC_IRQ: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
        irq_go |=> epc_r == $past(core_next_pc) && cause_r[4:0] == $past(req_id_r))
        else $error("interrupt entry did not save pc and number");

    AST_CAUSE_FLAG: assert property (@(posedge clk) disable iff (sys_rst) // RULE20
        trap_r.taken |-> cause_r[31] == trap_r.is_irq && cause_r[4:0] == trap_r.code)
        else $error("cause flag or code mismatch");

    AST_NO_CODE_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
        trap_r.taken && trap_r.is_irq |-> trap_r.code != 5'h00)
        else $error("interrupt trap with number zero");

    AST_TVAL_OPCODE: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        exc_in.valid && exc_in.code == 5'h02 |=> tval_r == $past(exc_in.opcode))
        else $error("trap value not the opcode");

    AST_VECTOR: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
        trap_r.taken && trap_r.is_irq
        |-> trap_r.target[7:0] == {1'b0, trap_r.code, 2'b00})
        else $error("vector offset not four times the number");

    AST_ENABLE_SAVE: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
        take |=> !global_irq_enable_r && prev_global_irq_enable_r == $past(global_irq_enable_r))
        else $error("global enable not saved and cleared");

    AST_NO_IRQ_MASKED: assert property (@(posedge clk) disable iff (sys_rst) // RULE22
        trap_r.taken && trap_r.is_irq |-> $past(global_irq_enable_r))
        else $error("interrupt trap with global enable clear");

    AST_LATENCY: assert property (@(posedge clk) disable iff (sys_rst) // RULE21
        (best_valid_r && global_irq_enable_r && !exc_in.valid && !core_mret
         && !csr_we && !reg_we) ##1 (pend[req_id_r] && global_irq_enable_r && !exc_in.valid)
        |=> trap_r.taken && trap_r.is_irq)
        else $error("selected interrupt not taken on time");

endmodule // vit_trap_ctrl

// ---- dv/vit_src_model.sv ----
// peripheral sources and core pipeline pc model facing the trap controller
`timescale 1ns/100ps
module vit_src_model
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [31:1] lvl_req,
    output logic      [31:1] irq_src,
    output logic      [31:0] next_pc
);
    // everything moves on the falling edge so the controller never samples mid-change
    always_ff @(negedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_src <= '0;
            next_pc <= 32'h4000_0000;
        end
        else
        begin
            irq_src <= lvl_req;
            // pc walks on every cycle so a stale capture shows up
            next_pc <= next_pc + 32'h0000_0002;
        end
    end
endmodule // vit_src_model

// ---- dv/vit_trap_ctrl_tb.sv ----
// self-checking bench for the vectored interrupt and trap controller
`timescale 1ns/100ps
module vit_trap_ctrl_tb;
    import vit_pkg::*;
    logic        clk       = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [31:1] lvl       = '0;
    logic [31:1] irq_src;
    logic [31:0] next_pc;
    logic [11:0] csr_addr  = 12'h000;
    logic        csr_we    = 1'b0;
    logic [31:0] csr_wdata = 32'h0;
    logic [31:0] csr_rdata_r;
    logic [11:0] reg_addr  = 12'h000;
    logic        reg_we    = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata_r;
    logic        core_mret = 1'b0;
    vit_exc_t    exc       = '0;
    logic [31:0] fetch_addr = 32'h0;
    logic [31:0] fetch_al;
    vit_trap_t   trap;
    logic [31:0] tv;
    logic [4:0]  c;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          trap_cnt  = 0;
    int          n;
    logic [4:0]  codes [7] = '{EXC_INSN_FAULT, EXC_ILLEGAL, EXC_BREAK, EXC_LOAD_FAULT,
                               EXC_STORE_FAULT, EXC_ECALL_U, EXC_ECALL_M};
    int          ps [5]    = '{3, 4, 5, 7, 9};
    logic [3:0]  pv [5]    = '{4'h2, 4'h7, 4'h3, 4'h5, 4'h5};

    vit_src_model src_u (.clk(clk), .sys_rst(sys_rst), .lvl_req(lvl), .irq_src(irq_src),
                         .next_pc(next_pc));
    vit_trap_ctrl #(.NUM_IRQ(31)) dut_u (.clk(clk), .sys_rst(sys_rst), .irq_src(irq_src),
        .csr_addr(csr_addr), .csr_we(csr_we), .csr_wdata(csr_wdata),
        .csr_rdata_r(csr_rdata_r), .reg_addr(reg_addr), .reg_we(reg_we),
        .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .core_next_pc(next_pc),
        .core_mret(core_mret), .exc_in(exc), .fetch_addr(fetch_addr),
        .fetch_addr_aligned(fetch_al), .trap_r(trap));

    initial
    begin
        forever #10 clk = ~clk;
    end

    // counted on the falling edge, half a cycle after the launching edge, so the registered pulse has settled
    always @(negedge clk)
    begin
        if (trap.taken === 1'b1)
            trap_cnt++;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    // r selects the controller bus, otherwise the csr bus; the other strobe stays low
    task automatic wr(input logic r, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        {csr_addr, reg_addr, csr_wdata, reg_wdata} = {a, a, d, d};
        {csr_we, reg_we} = {!r, r};
        @(negedge clk);
        {csr_we, reg_we} = 2'b00;
    endtask

    task automatic rd(input logic r, input logic [11:0] a, input logic [31:0] e,
                      input string nm);
        @(negedge clk);
        {csr_addr, reg_addr} = {a, a};
        @(posedge clk);
        #1 chk(nm, e, r ? reg_rdata_r : csr_rdata_r);
    endtask

    task automatic wait_trap(output int k);
        for (k = 1; k <= 20; k++)
        begin
            @(posedge clk);
            #1;
            if (trap.taken === 1'b1)
                return;
        end
        error_cnt++;
        $display("MISMATCH trap_taken exp 1 got 0");
        stop_test();
    endtask

    task automatic pulse(input int s);
        @(posedge clk);
        #1 lvl[s] = 1'b1;
        @(posedge clk);
        #1 lvl[s] = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        rd(0, CSR_TVEC_ADDR, 32'h0000_0001, "tvec_rst");
        rd(0, CSR_STATUS_ADDR, 32'h0000_0000, "status_rst");
        rd(1, INT_PEND_OFS, 32'h0000_0000, "pend_rst");
        wr(0, CSR_TVEC_ADDR, 32'h1234_56FF);
        rd(0, CSR_TVEC_ADDR, 32'h1234_5601, "tvec_base");
        wr(0, CSR_CAUSE_ADDR, 32'hFFFF_FFFF);
        rd(0, CSR_CAUSE_ADDR, 32'h8000_001F, "cause_sw");
        @(negedge clk);
        fetch_addr = 32'h4000_0103;
        #1 chk("fetch", 32'h4000_0102, fetch_al);
        foreach (codes[i])
        begin
            c = codes[i];
            @(negedge clk);
            exc = '{1'b1, c, 32'h4000_1000 + c, 32'hAB00_0000 + c, 32'h3FC0_0000 + c};
            tv = (c == EXC_INSN_FAULT) ? exc.pc : (c == EXC_ILLEGAL) ? exc.opcode :
                 (c == EXC_LOAD_FAULT || c == EXC_STORE_FAULT) ? exc.daddr : 32'h0;
            @(posedge clk);
            #1 chk("exc_kind", {25'h0, 1'b1, 1'b0, c}, {25'h0, trap.taken, trap.is_irq, trap.code});
            chk("exc_target", 32'h1234_5600, trap.target);
            @(negedge clk);
            exc.valid = 1'b0;
            rd(0, CSR_CAUSE_ADDR, {27'h0, c}, "exc_cause");
            rd(0, CSR_EPC_ADDR, exc.pc, "exc_epc");
            rd(0, CSR_TVAL_ADDR, tv, "exc_tval");
        end
        wr(1, INT_ENABLE_OFS, 32'hFFFF_FFFF);
        rd(1, INT_ENABLE_OFS, 32'hFFFF_FFFE, "enable_all");
        // sources 3, 4, 5, 7 and 9 enabled; 6 stays disabled
        wr(1, INT_ENABLE_OFS, 32'h0000_02B8);
        wr(1, INT_TYPE_OFS, 32'h0000_0010);
        foreach (ps[i])
            wr(1, INT_PRIO_OFS + 12'(4 * (ps[i] - 1)), {28'h0, pv[i]});
        n = trap_cnt;
        lvl = 31'h0000_0164;
        repeat (8) @(negedge clk);
        rd(1, INT_PEND_OFS, 32'h0000_0288, "pend_levels");
        chk("no_trap_gie_off", n, trap_cnt);
        wr(0, CSR_STATUS_ADDR, 32'h0000_0008);
        wait_trap(n);
        chk("arb_code", 32'h0000_0067, {25'h0, trap.taken, trap.is_irq, trap.code});
        chk("arb_target", 32'h1234_561C, trap.target);
        rd(0, CSR_STATUS_ADDR, 32'h0000_0080, "status_irq");
        rd(0, CSR_CAUSE_ADDR, 32'h8000_0007, "cause_irq");
        lvl = '0;
        repeat (3) @(negedge clk);
        core_mret = 1'b1;
        @(negedge clk);
        core_mret = 1'b0;
        rd(0, CSR_STATUS_ADDR, 32'h0000_0008, "status_mret");
        @(posedge clk);
        #1 lvl[5] = 1'b1;
        @(negedge clk);
        wait_trap(n);
        chk("irq_latency", IRQ_LATENCY, n);
        chk("irq_code", 32'h5, {27'h0, trap.code});
        chk("irq_target", 32'h1234_5614, trap.target);
        tv = next_pc;
        rd(0, CSR_EPC_ADDR, tv, "epc_irq");
        rd(0, CSR_CAUSE_ADDR, 32'h8000_0005, "cause_irq5");
        wr(1, INT_THRESH_OFS, 32'h0000_0004);
        repeat (2) @(negedge clk);
        rd(1, INT_PEND_OFS, 32'h0000_0000, "pend_below_thresh");
        wr(1, INT_THRESH_OFS, 32'h0000_0003);
        repeat (2) @(negedge clk);
        rd(1, INT_PEND_OFS, 32'h0000_0020, "pend_at_thresh");
        wr(1, INT_PRIO_OFS + 12'h010, 32'h0000_0000);
        repeat (2) @(negedge clk);
        rd(1, INT_PEND_OFS, 32'h0000_0000, "pend_prio_zero");
        wr(1, INT_PRIO_OFS + 12'h010, 32'h0000_0003);
        pulse(4);
        rd(1, INT_PEND_OFS, 32'h0000_0030, "pend_edge_held");
        wr(0, CSR_STATUS_ADDR, 32'h0000_0008);
        wait_trap(n);
        chk("edge_code", 32'h4, {27'h0, trap.code});
        wr(1, INT_CLEAR_OFS, 32'h0000_0030);
        wr(1, INT_CLEAR_OFS, 32'h0000_0000);
        repeat (2) @(negedge clk);
        rd(1, INT_PEND_OFS, 32'h0000_0020, "pend_after_clear");
        lvl[5] = 1'b0;
        pulse(4);
        rd(1, INT_PEND_OFS, 32'h0000_0010, "pend_unclaimed");
        wr(1, INT_ENABLE_OFS, 32'h0000_02A8);
        wr(1, INT_CLEAR_OFS, 32'h0000_0010);
        wr(1, INT_CLEAR_OFS, 32'h0000_0000);
        wr(1, INT_ENABLE_OFS, 32'h0000_02B8);
        repeat (2) @(negedge clk);
        rd(1, INT_PEND_OFS, 32'h0000_0000, "pend_flushed");
        stop_test();
    end
endmodule // vit_trap_ctrl_tb
